// file: jump_pkg.sv
/*
  Constants for the absolute jump decode and execute block.
  Assumes a 16-bit instruction word and a 16-bit program counter.
*/
package jump_pkg;
  localparam int          WORD_W      = 16;
  localparam int          LIT_W       = 13;
  localparam logic [2:0]  JUMP_OPCODE = 3'h6;
  localparam int          OPCODE_HI   = 15;
  localparam int          OPCODE_LO   = 13;
  localparam logic [12:0] LIT_MAX     = 13'h1fff;
  localparam logic [15:0] PC_RESET    = 16'h0000;
  localparam logic [7:0]  LATCH_RESET = 8'h00;

  typedef enum logic [3:0]
  {
    Q1 = 4'b0001,
    Q2 = 4'b0010,
    Q3 = 4'b0100,
    Q4 = 4'b1000
  } quarter_type;

  typedef enum logic [1:0]
  {
    ST_FIRST  = 2'b01,
    ST_FORCED = 2'b10
  } cycle_type;
endpackage : jump_pkg

// file: absolute_jump_execution.sv
/*
  Decode and execution of the absolute jump inside the core.
  Assumes the fetch path presents a new word at each Q1 and that the
  rest of the core honours nop_active by suppressing its own side effects.
*/
// Overview of operation
// - Top opcode bits 110 mark a jump.
// - Thirteen-bit literal spans the whole page.
// - Literal loads counter bits twelve to zero.
// - High latch takes literal top and page.
// - One word, always two instruction cycles.
// - Decode, read literal, execute, no write.
// - Second cycle is forced no-operation, discarding prefetch.
`timescale 1ns/100ps
module absolute_jump_execution
  import jump_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic [jump_pkg::WORD_W-1:0] instr,
  output logic      [15:0]             pc,
  output logic      [7:0]              pc_high_latch,
  output logic      [3:0]              quarter,
  output logic                         nop_active,
  output logic                         discard_fetch,
  output logic                         reg_write_en
);
  import jump_pkg::*;

  //////////////////////////////////////////////////////////////////////////

  quarter_type      phase;
  quarter_type      next_phase;
  cycle_type        state;
  cycle_type        next_state;
  logic [LIT_W-1:0] literal;
  logic [LIT_W-1:0] next_literal;
  logic [7:0]       lit_low;
  logic [7:0]       next_lit_low;
  logic             jump_held;
  logic             next_jump_held;
  logic [15:0]      next_pc;
  logic [7:0]       next_latch;
  logic             next_nop_active;
  logic             next_discard;

  //////////////////////////////////////////////////////////////////////////

  function automatic logic is_jump(input logic [WORD_W-1:0] w);
    is_jump = (w[OPCODE_HI:OPCODE_LO] == JUMP_OPCODE);
  endfunction : is_jump

  wire logic in_q1     = (phase == Q1);
  wire logic in_q2     = (phase == Q2);
  wire logic in_q3     = (phase == Q3);
  wire logic in_q4     = (phase == Q4);
  wire logic in_first  = (state == ST_FIRST);
  wire logic in_forced = (state == ST_FORCED);

  // Words are looked at only in Q1 of a normal cycle, so the word that
  // was prefetched behind a jump is dropped without further logic.
  wire logic decode_hit   = in_q1 && in_first && is_jump(instr);
  wire logic read_low     = in_q2 && in_first && jump_held;
  wire logic exec_now     = in_q3 && in_first && jump_held;
  wire logic enter_forced = in_q4 && in_first && jump_held;
  wire logic leave_forced = in_q4 && in_forced;

  // The full literal range is accepted, so there is no bound check.
  assign next_literal = decode_hit ? instr[LIT_W-1:0] : literal;
  assign next_lit_low = read_low ? literal[7:0] : lit_low;
  assign next_pc      = exec_now
                        ? {pc[15:13], literal[12:8], lit_low}
                        : pc;
  assign next_latch   = exec_now
                        ? {pc[15:13], literal[12:8]}
                        : pc_high_latch;

  // Set wins over clear, although the two never meet in one quarter.
  assign next_jump_held = decode_hit ? 1'b1
                        : (leave_forced ? 1'b0 : jump_held);

  // The forced cycle cannot be skipped, since no path leaves it early.
  assign next_state = enter_forced ? ST_FORCED
                    : (in_q4 ? ST_FIRST : state);
  assign next_nop_active = (next_state == ST_FORCED);
  assign next_discard    = enter_forced;

  always_comb
  begin
    unique case (phase)
      Q1: next_phase = Q2;
      Q2: next_phase = Q3;
      Q3: next_phase = Q4;
      Q4: next_phase = Q1;
      default: next_phase = Q1;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      phase <= Q1;
    end
    else
    begin
      phase <= next_phase;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state <= ST_FIRST;
    end
    else
    begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      literal <= '0;
    end
    else
    begin
      literal <= next_literal;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      lit_low <= 8'h00;
    end
    else
    begin
      lit_low <= next_lit_low;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      jump_held <= 1'b0;
    end
    else
    begin
      jump_held <= next_jump_held;
    end
  end

  // Counter and latch update together in Q3, so the latch sees the page
  // bits before any later instruction can change them.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pc <= PC_RESET;
    end
    else
    begin
      pc <= next_pc;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pc_high_latch <= LATCH_RESET;
    end
    else
    begin
      pc_high_latch <= next_latch;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      quarter <= Q1;
    end
    else
    begin
      quarter <= next_phase;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      nop_active <= 1'b0;
    end
    else
    begin
      nop_active <= next_nop_active;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      discard_fetch <= 1'b0;
    end
    else
    begin
      discard_fetch <= next_discard;
    end
  end

  // No flag, working register or memory strobe exists here; the write
  // enable stays low through both cycles of the jump.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      reg_write_en <= 1'b0;
    end
    else
    begin
      reg_write_en <= 1'b0;
    end
  end
endmodule : absolute_jump_execution

// file: fetch_model.sv
/* Fetch model. It assumes the block's quarter marks when Q1 starts. */
`timescale 1ns/100ps
module fetch_model (input wire logic clk,
  input wire logic [3:0] quarter,
  input wire logic [15:0] word,
  output logic [15:0] instr = 16'h0);
  // Toggles outside Q1, so the word shows inverted in Q2 and Q4 and true again in Q3.
  always @(posedge clk) instr <= quarter == 4'h8 ? word : ~instr;
endmodule : fetch_model

// file: absolute_jump_execution_sva.sv
/* Jump checks. It assumes only the block's own ports. */
`timescale 1ns/100ps
module jump_checker (input wire logic clk, rst_n, nop_active, discard_fetch,
  input wire logic reg_write_en,
  input wire logic [15:0] instr, pc,
  input wire logic [7:0] pc_high_latch,
  input wire logic [3:0] quarter);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire go = quarter == 4'h1 && !nop_active && instr[15:13] == 3'h6;
  pc_load_a: assert property (go |-> ##3
    pc == {$past(pc[15:13], 3), $past(instr[12:0], 3)}) else $error("pc");
  latch_fill_a: assert property (go |-> ##3
    pc_high_latch == pc[15:8]) else $error("latch");
  two_cycle_a: assert property (go |-> ##4
    nop_active [*4] ##1 !nop_active) else $error("nop");
  discard_a: assert property ($rose(nop_active) |->
    discard_fetch ##1 !discard_fetch) else $error("discard");
  no_write_a: assert property (!reg_write_en) else $error("write");
  quarter_walk_a: assert property (quarter == 4'h1 |=>
    quarter == 4'h2 ##1 quarter == 4'h4 ##1 quarter == 4'h8) else $error("q");
endmodule : jump_checker
bind absolute_jump_execution jump_checker i_jump_checker (.clk(clk),
  .rst_n(rst_n), .nop_active(nop_active), .discard_fetch(discard_fetch),
  .reg_write_en(reg_write_en), .instr(instr), .pc(pc),
  .pc_high_latch(pc_high_latch), .quarter(quarter));

// file: absolute_jump_execution_bench.sv
/* Jump bench. It assumes the fetch model and the checker. */
`timescale 1ns/100ps
module absolute_jump_execution_bench;
  import jump_pkg::*;
  logic clk = 0, rst_n = 0, p = 0, nop_active, discard_fetch, reg_write_en;
  logic [15:0] word = 0, instr, pc, q[$];
  logic [7:0] pc_high_latch;
  logic [3:0] quarter;
  logic [31:0] w;
  int seed = 32'he4e1bc65, fail_count = 0, compares = 0;
  always #25 clk = ~clk;
  fetch_model i_fetch_model (.clk(clk), .quarter(quarter), .word(word),
    .instr(instr));
  absolute_jump_execution i_absolute_jump_execution (.clk(clk),
    .rst_n(rst_n), .instr(instr), .pc(pc), .pc_high_latch(pc_high_latch),
    .quarter(quarter), .nop_active(nop_active),
    .discard_fetch(discard_fetch), .reg_write_en(reg_write_en));
  task automatic check(input logic [15:0] e);
    compares++;
    if ({pc, pc_high_latch} === {e, e[15:8]}) return;
    fail_count++;
    $display("[ERR] %0t bad jump", $time);
  endtask : check
  task automatic wrap_up(input int late);
    fail_count += late;
    if (fail_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up
  // A word picked at the end of Q3 is shown by the model in the next Q1.
  always @(posedge clk)
    if (rst_n && quarter == 4'h4)
    begin
      w = $random(seed);
      if (w[17]) w[12:0] = {13{w[18]}};
      word <= w[15:0];
      p <= !p && w[15:13] == 3'h6;
      if (!p && w[15:13] == 3'h6) q.push_back({PC_RESET[15:13], w[12:0]});
    end
  always @(posedge clk)
    if (rst_n && discard_fetch)
    begin
      if (q.size() == 0)
      begin
        fail_count++;
        $display("[ERR] %0t jump with no expected target", $time);
      end
      else check(q.pop_front());
    end
  initial #175 rst_n <= 1'b1;
  initial wait (compares == 60) wrap_up(0);
  initial #900000 wrap_up(1);
endmodule : absolute_jump_execution_bench
